// >>> usb_irq_defines.vh
/*
 Register offsets, field positions, reset values and timing counts
 for the device interrupt status collector.
 Assumes a 20 MHz controller clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef USB_IRQ_DEFINES_VH
`define USB_IRQ_DEFINES_VH

// Register byte offsets
`define OFS_IRQ_STATUS      12'h218
`define OFS_IRQ_MASK        12'h21c
`define OFS_IRQ_CTRL        12'h220

// Reset values
`define IRQ_STATUS_RST      32'h0000_0000
`define IRQ_MASK_RST        32'hffff_ffff
`define IRQ_CTRL_RST        32'h0000_0000

// Field positions of the status register
`define BIT_BUS_RESET       0
`define BIT_SOF             1
`define BIT_INT_FRAME       2
`define BIT_SUSPEND         3
`define BIT_RESUME          4
`define BIT_HS_CHANGE       5
`define BIT_DMA             6
`define BIT_VBUS            7
`define BIT_SETUP           8
`define BIT_EP_RX0          10
`define BIT_EP_TX0          11
`define NUM_EP              8

// Implemented bits; 31..26 and 9 are reserved
`define IRQ_USED_MASK       32'h03ff_fdff

// Control register fields
`define BIT_DUAL_ROLE_OFF   0
`define BIT_HIGH_SPEED      1

// Internal frame timer periods and cycle counts at 20 MHz
`define CLK_HZ              20000000
`define FS_FRAME_US         1000
`define HS_FRAME_US         125
`define FS_FRAME_CYC        ((`CLK_HZ / 1000000) * `FS_FRAME_US)
`define HS_FRAME_CYC        ((`CLK_HZ / 1000000) * `HS_FRAME_US)
// Frame timer periods as 16-bit counter loads
`define FS_FRAME_CNT        16'h4e20
`define HS_FRAME_CNT        16'h09c4

// AXI response codes
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// >>> usb_device_irq_status.v
/*
 Interrupt status collector for the peripheral side of a USB device
 controller, with an AXI4-Lite register slave and one level interrupt.
 Assumes event inputs are one-cycle pulses or levels synchronous to aclk,
 and that the DMA reason register lives elsewhere and signals its changes.
*/
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "usb_irq_defines.vh"

// Summary of operation
// - Endpoint n sets bit 11+2n on transmit event, 10+2n on receive event.
// - SETUP token on control endpoint zero sets bit 8.
// - Low-to-high transition on the VBUS sense input sets bit 7.
// - Any change in the DMA reason register sets bit 6.
// - Full-speed to high-speed change sets bit 5, never on suspend.
// - Bus change from suspended to active sets bit 4.
// - Bus change from active to suspended sets bit 3.
// - Free-running frame timer, 1 ms full speed, 125 us high speed, sets bit 2.
// - Each received start-of-frame or microframe marker sets bit 1.
// - Detected bus reset sets bit 0.
// - Interrupt output asserted while any status bit whose mask bit is one is set.
// - Writing one clears a status bit; writing zero leaves it alone.
module usb_device_irq_status
(
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite slave
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Event sources
   input  wire [7:0]  endpoint_tx_flag,
   input  wire [7:0]  endpoint_rx_flag,
   input  wire        control_setup_flag,
   input  wire        vbus_sense,
   input  wire        dma_reason_changed,
   input  wire        high_speed_link,
   input  wire        bus_suspended,
   input  wire        sof_received,
   input  wire        bus_reset_detected,
   // Outputs
   output reg         irq,
   output reg         dual_role_off
);

   // Status, mask and control registers
   reg  [31:0] irq_status_r;
   reg  [31:0] irq_status_nxt;
   reg  [31:0] irq_mask_r;
   reg  [1:0]  ctrl_r;
   // Edge history for level inputs, and frame timer
   reg         vbus_d_r;
   reg         hs_d_r;
   reg         suspend_flag_d_r;
   reg  [15:0] frame_cnt_r;
   reg         frame_tick_r;
   // Write channel capture
   reg         aw_held_r;
   reg  [11:0] aw_addr_r;
   reg         w_held_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;
   // Read sequencer states, one-hot
   localparam RD_IDLE    = 3'h1;
   localparam RD_OFFER   = 3'h2;
   localparam RD_ANSWER  = 3'h4;
   reg  [2:0]  rd_state_r;
   // Register select codes from the address decoder
   localparam REG_NONE   = 2'h0;
   localparam REG_STATUS = 2'h1;
   localparam REG_MASK   = 2'h2;
   localparam REG_CTRL   = 2'h3;

   wire [31:0] event_set;
   wire [31:0] wmask;
   wire        wr_fire;
   wire        wr_status;
   wire        wr_mask;
   wire        wr_ctrl;
   wire        wr_unmapped;
   wire [15:0] frame_period;

   // Byte-enable expansion, used for status and mask register writes
   function [31:0] strb_mask;
      input [3:0] s;
      begin
         strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      end
   endfunction

   // Word-address decode, shared by read and write paths
   function [1:0] decode;
      input [11:0] a;
      begin
         case ({a[11:2], 2'h0})
            `OFS_IRQ_STATUS: decode = REG_STATUS;
            `OFS_IRQ_MASK:   decode = REG_MASK;
            `OFS_IRQ_CTRL:   decode = REG_CTRL;
            default:         decode = REG_NONE;
         endcase
      end
   endfunction

   assign wmask   = strb_mask(w_strb_r);
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

   // Write target, decoded once for storage and response alike
   assign wr_status   = wr_fire && (decode(aw_addr_r) == REG_STATUS);
   assign wr_mask     = wr_fire && (decode(aw_addr_r) == REG_MASK);
   assign wr_ctrl     = wr_fire && (decode(aw_addr_r) == REG_CTRL);
   assign wr_unmapped = (decode(aw_addr_r) == REG_NONE);

   // Per-endpoint event placement
   genvar ep;
   generate
      for (ep = 0; ep < `NUM_EP; ep = ep + 1)
      begin : g_ep
         assign event_set[`BIT_EP_RX0 + 2*ep] = endpoint_rx_flag[ep];
         assign event_set[`BIT_EP_TX0 + 2*ep] = endpoint_tx_flag[ep];
      end
   endgenerate

   // Bus-state events; reserved bits never set
   assign event_set[31:26]          = 6'h00;
   assign event_set[9]              = 1'b0;
   assign event_set[`BIT_SETUP]     = control_setup_flag;
   assign event_set[`BIT_VBUS]      = vbus_sense & ~vbus_d_r;
   assign event_set[`BIT_DMA]       = dma_reason_changed;
   // Rising speed only while not suspended, so suspend never flags it
   assign event_set[`BIT_HS_CHANGE] = high_speed_link & ~hs_d_r & ~bus_suspended;
   assign event_set[`BIT_RESUME]    = ~bus_suspended & suspend_flag_d_r;
   assign event_set[`BIT_SUSPEND]   = bus_suspended & ~suspend_flag_d_r;
   assign event_set[`BIT_INT_FRAME] = frame_tick_r;
   assign event_set[`BIT_SOF]       = sof_received;
   assign event_set[`BIT_BUS_RESET] = bus_reset_detected;

   // Frame timer period follows the current link speed
   assign frame_period = high_speed_link ? `HS_FRAME_CNT : `FS_FRAME_CNT;

   // Free-running frame timer, not aligned to bus frame markers
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         frame_cnt_r  <= 16'h0000;
         frame_tick_r <= 1'b0;
      end
      else if (frame_cnt_r >= frame_period - 16'h0001)
      begin
         frame_cnt_r  <= 16'h0000;
         frame_tick_r <= 1'b1;
      end
      else
      begin
         frame_cnt_r  <= frame_cnt_r + 16'h0001;
         frame_tick_r <= 1'b0;
      end
   end

   // Edge detection history
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         vbus_d_r <= vbus_sense;        // Pin levels, so no false edge after reset
         hs_d_r   <= high_speed_link;
         suspend_flag_d_r <= bus_suspended;
      end
      else
      begin
         vbus_d_r <= vbus_sense;
         hs_d_r   <= high_speed_link;
         suspend_flag_d_r <= bus_suspended;
      end
   end

   // Next status: clear by write-one, then set wins over clear
   always @*
   begin
      irq_status_nxt = irq_status_r;
      if (wr_status)
         irq_status_nxt = irq_status_nxt & ~(w_data_r & wmask);
      // A bus reset wipes everything but its own flag
      if (bus_reset_detected)
         irq_status_nxt = irq_status_nxt & (32'h1 << `BIT_BUS_RESET);
      irq_status_nxt = (irq_status_nxt | event_set) & `IRQ_USED_MASK;
   end

   // Status, mask and control storage
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_status_r <= `IRQ_STATUS_RST;
         irq_mask_r   <= `IRQ_MASK_RST;
         ctrl_r       <= 2'h0;
      end
      else
      begin
         irq_status_r <= irq_status_nxt;
         if (wr_mask)
            irq_mask_r <= (irq_mask_r & ~wmask) | (w_data_r & wmask);
         if (wr_ctrl && w_strb_r[0])
            ctrl_r <= w_data_r[1:0];
      end
   end

   // Interrupt and control outputs, registered; masked bits stay quiet
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq           <= 1'b0;
         dual_role_off <= 1'b0;
      end
      else
      begin
         irq           <= |(irq_status_nxt & irq_mask_r);
         dual_role_off <= ctrl_r[`BIT_DUAL_ROLE_OFF];
      end
   end

   // Write address and data are taken independently, in either order
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r     <= 1'b0;
         aw_addr_r     <= 12'h000;
         w_held_r      <= 1'b0;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         // Register update happens in the cycle the response is raised
         if (wr_fire)
         begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_unmapped ? `RESP_SLVERR : `RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: one-hot sequencer, one outstanding read, current register data
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state_r    <= RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end
      else
      begin
         case (rd_state_r)
            // Offer arready for one cycle before every read
            RD_IDLE:
            begin
               s_axi_arready <= 1'b1;
               rd_state_r    <= RD_OFFER;
            end
            // Take the address if it stands, else withdraw the offer
            RD_OFFER:
            begin
               s_axi_arready <= 1'b0;
               rd_state_r    <= RD_IDLE;
               if (s_axi_arvalid)
               begin
                  rd_state_r   <= RD_ANSWER;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp  <= `RESP_OKAY;
                  case (decode(s_axi_araddr))
                     REG_STATUS: s_axi_rdata <= irq_status_r;
                     REG_MASK:   s_axi_rdata <= irq_mask_r;
                     REG_CTRL:   s_axi_rdata <= {30'h0, ctrl_r};
                     default:
                     begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                     end
                  endcase
               end
            end
            // Data stands until the master takes it
            RD_ANSWER:
            begin
               if (s_axi_rready)
               begin
                  s_axi_rvalid <= 1'b0;
                  rd_state_r   <= RD_IDLE;
               end
            end
            default:
            begin
               rd_state_r    <= RD_IDLE;
               s_axi_arready <= 1'b0;
               s_axi_rvalid  <= 1'b0;
            end
         endcase
      end
   end

endmodule // usb_device_irq_status

// >>> usb_irq_chk.sv
/* Port checker for the irq status collector.
   Assumes it is bound to usb_device_irq_status, one clock domain. */
`timescale 1ns/1ps
`include "usb_irq_defines.vh"
module usb_irq_chk
(
   input wire        aclk,
   input wire        aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [7:0]  endpoint_tx_flag,
   input wire        control_setup_flag,
   input wire        bus_reset_detected,
   input wire        irq,
   input wire        dual_role_off
);
   reg mask_all_r;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Mask unknown once software has touched it, so irq rules need it untouched
   always @(posedge aclk)
      if (!aresetn)
         mask_all_r <= 1'b1;
      else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `OFS_IRQ_MASK)
         mask_all_r <= 1'b0;
   reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !irq && !dual_role_off)
      else $error("outputs not quiet after reset");
   event_irq_a: assert property (mask_all_r
      && (|endpoint_tx_flag || control_setup_flag || bus_reset_detected) |-> ##[1:2] irq)
      else $error("event did not raise irq");
   // A write-one clear lands at the very edge that raises bvalid
   irq_sticky_a: assert property (mask_all_r && irq |=> irq || $rose(s_axi_bvalid))
      else $error("irq dropped without a write");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held");
   ready_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready during pending response");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   write_answer_a: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
      else $error("write not answered");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid held after handshake");
endmodule // usb_irq_chk
bind usb_device_irq_status usb_irq_chk chk_u (.*);

// >>> usb_irq_cpu.sv
/* Microprocessor model: AXI4-Lite master servicing the irq collector.
   Assumes the bench top offers a hang task for timeouts. */
`timescale 1ns/1ps
`include "usb_irq_defines.vh"
module usb_irq_cpu
(
   input  wire        aclk,
   output reg  [11:0] s_axi_awaddr = 12'h000,
   output reg         s_axi_awvalid = 1'b0,
   input  wire        s_axi_awready,
   output reg  [31:0] s_axi_wdata = 32'h0000_0000,
   output reg  [3:0]  s_axi_wstrb = 4'hf,
   output reg         s_axi_wvalid = 1'b0,
   input  wire        s_axi_wready,
   input  wire        s_axi_bvalid,
   output reg         s_axi_bready = 1'b0,
   output reg  [11:0] s_axi_araddr = 12'h000,
   output reg         s_axi_arvalid = 1'b0,
   input  wire        s_axi_arready,
   input  wire        s_axi_rvalid,
   output reg         s_axi_rready = 1'b0
);
   // Slow to take the response, so it must stand
   task wr(input [11:0] a, input [31:0] d);
      integer n;
   begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata  <= (a == `OFS_IRQ_STATUS) ? d & `IRQ_USED_MASK : d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
         n = n + 1;
      end
      while (!(s_axi_bvalid && s_axi_bready) && n < 40);
      s_axi_bready <= 1'b0;
      if (n >= 40) usb_device_irq_status_tb_top.hang;
   end
   endtask
   // Prompt reader
   task rd(input [11:0] a);
      integer n;
   begin
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n = n + 1;
      end
      while (!s_axi_rvalid && n < 40);
      s_axi_rready <= 1'b0;
      if (n >= 40) usb_device_irq_status_tb_top.hang;
   end
   endtask
endmodule // usb_irq_cpu

// >>> usb_device_irq_status_tb_top.sv
/* Bench for the irq collector: events, W1C, mask, frame tick.
   Assumes the cpu model drives the bus; answers scored from queues. */
`timescale 1ns/1ps
`include "usb_irq_defines.vh"
module usb_device_irq_status_tb_top;
   reg         aclk = 1'b0, aresetn = 1'b0, irq_q = 1'b0;
   wire [11:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0]  s_axi_wstrb;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, dual_role_off;
   reg  [7:0]  endpoint_tx_flag = 8'h00, endpoint_rx_flag = 8'h00;
   reg         control_setup_flag = 1'b0, vbus_sense = 1'b0, dma_reason_changed = 1'b0, sof_received = 1'b0;
   reg         high_speed_link = 1'b0, bus_suspended = 1'b0, bus_reset_detected = 1'b0;
   integer     num_errors = 0, n_tests = 0, gap = 0, gap_seen = 0, i, n;
   reg  [31:0] v, e;
   reg  [33:0] exp_r[$];
   reg  [1:0]  exp_b[$];
   usb_device_irq_status dut_u (.*);
   usb_irq_cpu cpu_u (.*);
   initial forever #25 aclk = ~aclk;
   task chk_w(input [63:0] what, input [33:0] x, input [33:0] g);
   begin
      n_tests = n_tests + 1;
      if (g !== x)
      begin
         num_errors = num_errors + 1;
         $display("wrong value %0s expected %h seen %h", what, x, g);
      end
   end
   endtask
   task chk_v(input [63:0] what, input [31:0] x, input [31:0] g);
   begin
      chk_w(what, {2'b00, x}, {2'b00, g});
   end
   endtask
   // Answers scored against the oldest note; irq rise spacing measured
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready) chk_w("rdata", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready) chk_w("bresp", {32'h0, exp_b.pop_front()}, {32'h0, s_axi_bresp});
      irq_q <= irq;
      gap <= (irq && !irq_q) ? 1 : gap + 1;
      if (irq && !irq_q) gap_seen <= gap;
   end
   task get(input [11:0] a, input [1:0] r, input [31:0] d);
   begin
      exp_r.push_back({r, d});
      cpu_u.rd(a);
   end
   endtask
   task put(input [11:0] a, input [31:0] d, input [1:0] r);
   begin
      exp_b.push_back(r);
      cpu_u.wr(a, d);
   end
   endtask
   // Raise the cause of one status bit; only bus_suspended stays where left
   task fire(input integer b);
   begin
      @(posedge aclk);
      case (b)
         0: bus_reset_detected <= 1'b1;
         1: sof_received <= 1'b1;
         3: bus_suspended <= 1'b1;
         4: bus_suspended <= 1'b0;
         5: high_speed_link <= 1'b1;
         6: dma_reason_changed <= 1'b1;
         7: vbus_sense <= 1'b1;
         8: control_setup_flag <= 1'b1;
         default: if (b[0]) endpoint_tx_flag[(b-11)/2] <= 1'b1; else endpoint_rx_flag[(b-10)/2] <= 1'b1;
      endcase
      @(posedge aclk);
      {bus_reset_detected, sof_received, high_speed_link, dma_reason_changed, vbus_sense} <= 5'h00;
      {control_setup_flag, endpoint_tx_flag, endpoint_rx_flag} <= 17'h00000;
   end
   endtask
   task wait_irq;
   begin
      repeat (3) @(posedge aclk);
      for (n = 0; irq !== 1'b1 && n < 21000; n = n + 1) @(posedge aclk);
      if (n >= 21000) hang;
   end
   endtask
   // Tick spacing judged from the second of two irq rises
   task frame(input integer want);
   begin
      repeat (2)
      begin
         put(`OFS_IRQ_STATUS, 32'hffff_ffff, `RESP_OKAY);
         wait_irq;
      end
      @(posedge aclk);
      chk_v("gap", want, gap_seen);
   end
   endtask
   task hang;
   begin
      num_errors = num_errors + 1;
      conclude;
   end
   endtask
   task conclude;
   begin
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   initial
   begin
      v = $urandom(32'h4c9f4e2e);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      get(`OFS_IRQ_STATUS, `RESP_OKAY, `IRQ_STATUS_RST);
      get(`OFS_IRQ_MASK, `RESP_OKAY, `IRQ_MASK_RST);
      put(`OFS_IRQ_CTRL, 32'h1, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk_v("role", 32'h1, {31'h0, dual_role_off});
      for (i = 0; i < 26; i = i + 1)
         if (i != 2 && i != 9)
         begin
            put(`OFS_IRQ_STATUS, 32'hffff_ffff, `RESP_OKAY);
            fire(i);
            get(`OFS_IRQ_STATUS, `RESP_OKAY, 32'h1 << i);
         end
      put(`OFS_IRQ_STATUS, 32'hffff_ffff, `RESP_OKAY);
      fire(3);
      fire(5);
      get(`OFS_IRQ_STATUS, `RESP_OKAY, 32'h8);
      fire(4);
      fire(8);
      get(`OFS_IRQ_STATUS, `RESP_OKAY, 32'h118);
      fire(0);
      get(`OFS_IRQ_STATUS, `RESP_OKAY, 32'h1);
      v = $urandom;
      @(posedge aclk);
      {endpoint_tx_flag, endpoint_rx_flag} <= v[15:0];
      @(posedge aclk);
      {endpoint_tx_flag, endpoint_rx_flag} <= 16'h0000;
      e = 32'h1;
      for (i = 0; i < 8; i = i + 1) e = e | ({31'h0, v[8+i]} << (11 + 2 * i)) | ({31'h0, v[i]} << (10 + 2 * i));
      v = $urandom;
      put(`OFS_IRQ_STATUS, v, `RESP_OKAY);
      get(`OFS_IRQ_STATUS, `RESP_OKAY, e & ~v & `IRQ_USED_MASK);
      put(`OFS_IRQ_STATUS, 32'hffff_ffff, `RESP_OKAY);
      fire(8);
      put(`OFS_IRQ_MASK, 32'hffff_feff, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk_v("irq", 32'h0, {31'h0, irq});
      put(`OFS_IRQ_MASK, 32'hffff_ffff, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk_v("irq", 32'h1, {31'h0, irq});
      put(`OFS_IRQ_STATUS, 32'h100, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk_v("irq", 32'h0, {31'h0, irq});
      put(12'h224, 32'h0, `RESP_SLVERR);
      get(12'h224, `RESP_SLVERR, 32'h0);
      fire(8);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      get(`OFS_IRQ_STATUS, `RESP_OKAY, `IRQ_STATUS_RST);
      frame(`FS_FRAME_CYC);
      high_speed_link <= 1'b1;
      frame(`HS_FRAME_CYC);
      conclude;
   end
endmodule // usb_device_irq_status_tb_top
